//--- rtl/fsp_pkg.sv
// constants, types and register map of the four mode serial port
package fsp_pkg;
  // ----------------------------------------------------------------
  // register byte addresses on the AXI4-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BUFFER  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_POWER   = 8'h08;
  localparam logic [7:0] ADDR_AUX     = 8'h0c;
  localparam logic [7:0] ADDR_TIMER1  = 8'h10;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         POW_BAUD_DOUBLE = 7;
  localparam int         POW_FE_SELECT   = 6;
  localparam int         AUX_T1_FAST     = 6;
  localparam int         AUX_M0_FAST     = 5;
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] POWER_RST       = 8'h00;
  localparam logic [7:0] AUX_RST         = 8'h00;
  localparam logic [7:0] TIMER1_RST      = 8'h00;
  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] M0_HALF_SLOW  = 3'h6;  // shift clock = clk/12
  localparam logic [2:0] M0_HALF_FAST  = 3'h1;  // shift clock = clk/2
  localparam logic [3:0] M0_LAST_BIT   = 4'h7;
  localparam logic [7:0] M0_PRESET     = 8'hfe;
  localparam logic [3:0] T1_PRE_LAST   = 4'hb;  // timer 1 prescale of 12
  localparam logic [2:0] M2_TICK_SLOW  = 3'h4;  // 16x of clk/64
  localparam logic [2:0] M2_TICK_FAST  = 3'h2;  // 16x of clk/32
  localparam logic [3:0] OVS_LAST      = 4'hf;  // 16 samples per bit
  localparam logic [3:0] SAMPLE_A      = 4'h7;
  localparam logic [3:0] SAMPLE_B      = 4'h8;
  localparam logic [3:0] SAMPLE_C      = 4'h9;
  localparam logic [3:0] FRAME10_LAST  = 4'h9;
  localparam logic [3:0] FRAME11_LAST  = 4'ha;
  localparam logic [3:0] RX_DELIVER    = 4'h9;
  localparam logic [3:0] RX_STOP11     = 4'ha;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M0_IDLE, M0_PRESET_ST, M0_TX, M0_RX} fsp_m0_e;
  typedef enum logic {RX_IDLE, RX_FRAME} fsp_rx_e;
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multi_proc;
    logic receiver_on;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } fsp_ctrl_s;
endpackage : fsp_pkg

//--- rtl/fsp_serial_port.sv
// four mode serial port with AXI4-Lite register slave
`timescale 1ns/100ps
// How it works
// - new byte may arrive while old unread; unread old blocks delivery, new lost.
// - buffer write loads transmit holder; buffer read returns separate receive buffer.
// - mode 0 data LSB first on rxd pin, txd drives shift clock clk/12 or clk/2.
// - mode 1 frame is start 0, eight data bits LSB first, stop 1.
// - modes 2,3 add ninth bit from tx_ninth_bit; received ninth goes to rx_ninth_bit.
// - mode 2 bit rate clk/64 or clk/32; mode 3 uses timer 1 instead.
// - buffer write starts a transmission in every mode; in mode 0 only while the shift engine is idle.
// - mode 0 transmit: bit per rising shift edge, tx_done_flag after eight rises.
// - mode 0 receive starts on receiver_on and clear rx_done_flag, preset 11111110.
// - mode 0 receive samples on falling edges, rx_done_flag after eight falls.
// - pending async transmit starts at next transmit bit clock tick.
// - tx_done_flag after eighth data bit in mode 1, ninth in modes 2,3.
// - buffer write captures tx_ninth_bit, or 1 in mode 1, into ninth shift position.
// - async receive starts on 1-to-0 seen by sample clock, majority bit detector.
// - mode 1 middle of stop bit sets rx_done_flag and stores stop in rx_ninth_bit.
// - modes 2,3 middle of ninth bit set rx_done_flag, store ninth bit.
// - missing stop bit sets frame_error_flag.
// - control bit 7 is frame_error_flag when frame_error_select set, else mode_select_high.
// - frame_error_flag is cleared only by software write.
// - modes 1,3 bit rate is 2^baud_double/32 of timer 1 reload overflow.
module fsp_serial_port (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // axi4-lite write
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // axi4-lite read
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // serial pins
  input  wire logic        i_rxd,
  output logic             o_rxd_out,
  output logic             o_rxd_oe,
  output logic             o_txd
);
  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic                 awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic                 aw_full_q, w_full_q;
  logic [7:0]           aw_addr_q, wdata_q;
  logic                 wstrb0_q;
  logic [1:0]           bresp_q, rresp_q;
  logic [31:0]          rdata_q;
  fsp_pkg::fsp_ctrl_s   ctrl_q, ctrl_d;
  logic [7:0]           power_q, aux_q, reload_q, rxbuf_q;
  logic                 fe_q;

  wire aw_hs   = i_awvalid & awready_q;
  wire w_hs    = i_wvalid & wready_q;
  wire ar_hs   = i_arvalid & arready_q;
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_byte = wr_fire & wstrb0_q;
  wire wr_buf  = wr_byte & (aw_addr_q == fsp_pkg::ADDR_BUFFER);
  wire wr_ctrl = wr_byte & (aw_addr_q == fsp_pkg::ADDR_CONTROL);
  wire wr_pow  = wr_byte & (aw_addr_q == fsp_pkg::ADDR_POWER);
  wire wr_aux  = wr_byte & (aw_addr_q == fsp_pkg::ADDR_AUX);
  wire wr_rel  = wr_byte & (aw_addr_q == fsp_pkg::ADDR_TIMER1);
  wire wr_hit  = (aw_addr_q == fsp_pkg::ADDR_BUFFER) | (aw_addr_q == fsp_pkg::ADDR_CONTROL) |
                 (aw_addr_q == fsp_pkg::ADDR_POWER) | (aw_addr_q == fsp_pkg::ADDR_AUX) |
                 (aw_addr_q == fsp_pkg::ADDR_TIMER1);
  wire fsel    = power_q[fsp_pkg::POW_FE_SELECT];
  wire smod    = power_q[fsp_pkg::POW_BAUD_DOUBLE];
  wire [7:0] ctrl_rd = {fsel ? fe_q : ctrl_q.mode_select_high, ctrl_q[6:0]};
  wire [7:0] ra      = i_araddr[7:0];
  wire rd_hit  = (ra == fsp_pkg::ADDR_BUFFER) | (ra == fsp_pkg::ADDR_CONTROL) | (ra == fsp_pkg::ADDR_POWER) |
                 (ra == fsp_pkg::ADDR_AUX) | (ra == fsp_pkg::ADDR_TIMER1);
  wire [7:0] rd_byte = (ra == fsp_pkg::ADDR_BUFFER)  ? rxbuf_q :
                       (ra == fsp_pkg::ADDR_CONTROL) ? ctrl_rd :
                       (ra == fsp_pkg::ADDR_POWER)   ? power_q :
                       (ra == fsp_pkg::ADDR_AUX)     ? aux_q :
                       (ra == fsp_pkg::ADDR_TIMER1)  ? reload_q : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      {awready_q, wready_q, bvalid_q, aw_full_q, w_full_q} <= 5'h00;
      {aw_addr_q, wdata_q, wstrb0_q, bresp_q} <= 19'h00000;
    end else begin
      awready_q <= aw_hs ? 1'b0 : (~aw_full_q & ~bvalid_q);
      wready_q  <= w_hs ? 1'b0 : (~w_full_q & ~bvalid_q);
      if (aw_hs) begin
        aw_addr_q <= i_awaddr[7:0];
        aw_full_q <= 1'b1;
      end
      if (w_hs) begin
        wdata_q  <= i_wdata[7:0];
        wstrb0_q <= i_wstrb[0];
        w_full_q <= 1'b1;
      end
      if (wr_fire) begin
        {aw_full_q, w_full_q, bvalid_q} <= 3'h1;
        bresp_q <= wr_hit ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      {arready_q, rvalid_q, rresp_q} <= 4'h0;
      rdata_q <= 32'h00000000;
    end else begin
      arready_q <= ar_hs ? 1'b0 : ~rvalid_q;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h000000, rd_byte};
        rresp_q  <= rd_hit ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (rvalid_q & i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // baud sources
  // ----------------------------------------------------------------
  logic [3:0] t1_pre_q;
  logic [7:0] t1_q;
  logic       t1_half_q;
  logic [2:0] m2_q;
  logic [3:0] txdiv_q;
  wire [1:0] mode     = {ctrl_q.mode_select_high, ctrl_q.mode_select_low};
  wire       is_m0    = (mode == 2'h0);
  wire       is_m1    = (mode == 2'h1);
  wire       is_m2    = (mode == 2'h2);
  wire       t1_inc   = aux_q[fsp_pkg::AUX_T1_FAST] | (t1_pre_q == fsp_pkg::T1_PRE_LAST);
  wire       t1_ovf   = t1_inc & (t1_q == 8'hff);
  wire       t1_tick  = t1_ovf & (smod | t1_half_q);
  wire [2:0] m2_limit = smod ? fsp_pkg::M2_TICK_FAST : fsp_pkg::M2_TICK_SLOW;
  wire       m2_tick  = (m2_q == m2_limit - 3'h1);
  wire       stick    = is_m2 ? m2_tick : t1_tick;
  wire       tx_tick  = stick & (txdiv_q == fsp_pkg::OVS_LAST);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      {t1_pre_q, t1_q, t1_half_q, m2_q, txdiv_q} <= 20'h00000;
    end else begin
      t1_pre_q <= t1_inc ? 4'h0 : t1_pre_q + 4'h1;
      if (t1_ovf) begin
        t1_q      <= reload_q;  // 8-bit auto-reload
        t1_half_q <= ~t1_half_q;
      end else if (t1_inc) begin
        t1_q <= t1_q + 8'h01;
      end
      m2_q <= m2_tick ? 3'h0 : m2_q + 3'h1;
      if (stick) begin
        txdiv_q <= txdiv_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode 0 shift engine
  // ----------------------------------------------------------------
  fsp_pkg::fsp_m0_e m0_q;
  logic [2:0] half_q;
  logic [3:0] m0_cnt_q;
  logic [7:0] m0_sh_q;
  logic       sclk_q;
  wire       m0_run  = (m0_q == fsp_pkg::M0_TX) | (m0_q == fsp_pkg::M0_RX);
  wire [2:0] m0_half = aux_q[fsp_pkg::AUX_M0_FAST] ? fsp_pkg::M0_HALF_FAST : fsp_pkg::M0_HALF_SLOW;
  wire       m0_edge = m0_run & (half_q == m0_half - 3'h1);
  wire       m0_rise = m0_edge & ~sclk_q;
  wire       m0_fall = m0_edge & sclk_q;
  wire       sclk_d  = m0_run ? (sclk_q ^ m0_edge) : 1'b1;
  wire       m0_last = (m0_cnt_q == fsp_pkg::M0_LAST_BIT);
  wire       m0_ti   = (m0_q == fsp_pkg::M0_TX) & m0_rise & m0_last;
  wire       m0_ri   = (m0_q == fsp_pkg::M0_RX) & m0_fall & m0_last;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      m0_q <= fsp_pkg::M0_IDLE;
      {half_q, m0_cnt_q, m0_sh_q} <= 15'h0000;
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_d;
      half_q <= (m0_run & ~m0_edge) ? half_q + 3'h1 : 3'h0;
      case (m0_q)
        fsp_pkg::M0_IDLE: begin
          m0_cnt_q <= 4'h0;
          if (is_m0 & wr_buf) begin
            m0_sh_q <= wdata_q;
            m0_q    <= fsp_pkg::M0_TX;
          end else if (is_m0 & ctrl_q.receiver_on & ~ctrl_q.rx_done_flag) begin
            m0_q <= fsp_pkg::M0_PRESET_ST;
          end
        end
        fsp_pkg::M0_PRESET_ST: begin
          m0_sh_q <= fsp_pkg::M0_PRESET;
          m0_q    <= fsp_pkg::M0_RX;
        end
        fsp_pkg::M0_TX: begin
          if (m0_fall) begin
            m0_sh_q <= {1'b0, m0_sh_q[7:1]};
          end
          if (m0_rise) begin
            m0_cnt_q <= m0_cnt_q + 4'h1;
            if (m0_last) begin
              m0_q <= fsp_pkg::M0_IDLE;
            end
          end
        end
        fsp_pkg::M0_RX: begin
          if (m0_fall) begin
            m0_sh_q  <= {i_rxd, m0_sh_q[7:1]};
            m0_cnt_q <= m0_cnt_q + 4'h1;
            if (m0_last) begin
              m0_q <= fsp_pkg::M0_IDLE;
            end
          end
        end
        default: m0_q <= fsp_pkg::M0_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // async transmitter
  // ----------------------------------------------------------------
  logic        pend_q, abusy_q, aline_q;
  logic [8:0]  thold_q;
  logic [10:0] ash_q;
  logic [3:0]  abit_q;
  wire [3:0] alast   = is_m1 ? fsp_pkg::FRAME10_LAST : fsp_pkg::FRAME11_LAST;
  wire       a_start = tx_tick & pend_q & ~abusy_q;
  wire       a_step  = tx_tick & abusy_q;
  wire       a_ti    = a_step & (abit_q + 4'h1 == alast);
  wire       aline_d = a_start ? 1'b0 : a_step ? ((abit_q == alast) | ash_q[1]) : aline_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      {pend_q, abusy_q, thold_q, ash_q, abit_q} <= 26'h0000000;
      aline_q <= 1'b1;
    end else begin
      aline_q <= aline_d;
      if (wr_buf & ~is_m0) begin
        pend_q  <= 1'b1;
        thold_q <= {is_m1 | ctrl_q.tx_ninth_bit, wdata_q};
      end else if (a_start) begin
        pend_q <= 1'b0;
      end
      if (a_start) begin
        abusy_q <= 1'b1;
        abit_q  <= 4'h0;
        ash_q   <= {1'b1, thold_q, 1'b0};
      end else if (a_step) begin
        abusy_q <= (abit_q != alast);
        abit_q  <= abit_q + 4'h1;
        ash_q   <= {1'b1, ash_q[10:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // async receiver with majority bit detector
  // ----------------------------------------------------------------
  fsp_pkg::fsp_rx_e rx_q;
  logic [3:0] rcnt_q, ridx_q;
  logic [7:0] rsh_q;
  logic       rprev_q, s7_q, s8_q;
  wire rx_on   = ~is_m0 & ctrl_q.receiver_on;
  wire maj     = (s7_q & s8_q) | (s7_q & i_rxd) | (s8_q & i_rxd);
  wire rdec    = (rx_q == fsp_pkg::RX_FRAME) & stick & (rcnt_q == fsp_pkg::SAMPLE_C);
  wire rx_del  = rdec & (ridx_q == fsp_pkg::RX_DELIVER);
  wire rx_take = rx_del & (~ctrl_q.rx_done_flag | (wr_ctrl & ~wdata_q[0]));
  wire rx_end  = rdec & ((is_m1 & ridx_q == fsp_pkg::RX_DELIVER) | (ridx_q == fsp_pkg::RX_STOP11));
  wire fe_set  = rx_end & ~maj;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_q <= fsp_pkg::RX_IDLE;
      {rcnt_q, ridx_q, rsh_q, s7_q, s8_q} <= 18'h00000;
      rprev_q <= 1'b1;
    end else if (!rx_on) begin
      rx_q    <= fsp_pkg::RX_IDLE;
      rprev_q <= 1'b1;
    end else if (stick) begin
      case (rx_q)
        fsp_pkg::RX_IDLE: begin
          rprev_q <= i_rxd;
          {rcnt_q, ridx_q} <= 8'h00;
          if (rprev_q & ~i_rxd) begin
            rx_q <= fsp_pkg::RX_FRAME;
          end
        end
        fsp_pkg::RX_FRAME: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == fsp_pkg::SAMPLE_A) s7_q <= i_rxd;
          if (rcnt_q == fsp_pkg::SAMPLE_B) s8_q <= i_rxd;
          if (rcnt_q == fsp_pkg::OVS_LAST) ridx_q <= ridx_q + 4'h1;
          if (rdec) begin
            if ((ridx_q == 4'h0 & maj) | rx_end) begin  // false start or frame done
              rx_q    <= fsp_pkg::RX_IDLE;
              rprev_q <= 1'b1;
            end
            if (ridx_q != 4'h0 & ridx_q < fsp_pkg::RX_DELIVER) begin
              rsh_q <= {maj, rsh_q[7:1]};
            end
          end
        end
        default: rx_q <= fsp_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control, status and buffers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wdata_q;
      if (fsel) ctrl_d.mode_select_high = ctrl_q.mode_select_high;
    end
    // hardware set wins over a simultaneous software clear
    if (m0_ti | a_ti) ctrl_d.tx_done_flag = 1'b1;
    if (m0_ri | rx_take) ctrl_d.rx_done_flag = 1'b1;
    if (rx_take) ctrl_d.rx_ninth_bit = maj;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl_q   <= fsp_pkg::CONTROL_RST;
      power_q  <= fsp_pkg::POWER_RST;
      aux_q    <= fsp_pkg::AUX_RST;
      reload_q <= fsp_pkg::TIMER1_RST;
      {rxbuf_q, fe_q} <= 9'h000;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_pow) power_q <= wdata_q;
      if (wr_aux) aux_q <= wdata_q;
      if (wr_rel) reload_q <= wdata_q;
      fe_q <= fe_set | ((wr_ctrl & fsel) ? wdata_q[7] : fe_q);
      if (m0_ri) rxbuf_q <= {i_rxd, m0_sh_q[7:1]};
      else if (rx_take) rxbuf_q <= rsh_q;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      {o_txd, o_rxd_out, o_rxd_oe} <= 3'h6;
    end else begin
      o_txd     <= is_m0 ? sclk_d : aline_d;
      o_rxd_out <= (m0_q == fsp_pkg::M0_TX & m0_fall) ? m0_sh_q[0] : o_rxd_out | ~o_rxd_oe;
      o_rxd_oe  <= (m0_q == fsp_pkg::M0_TX) & ~m0_ti;
    end
  end

  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence m0_tx_load; is_m0 & wr_buf & (m0_q == fsp_pkg::M0_IDLE); endsequence
  buf_start_a: assert property (m0_tx_load |=> m0_q == fsp_pkg::M0_TX) else $error("mode 0 write no start");
  m0_preset_a: assert property (m0_q == fsp_pkg::M0_PRESET_ST |=>
    m0_sh_q == fsp_pkg::M0_PRESET && m0_q == fsp_pkg::M0_RX) else $error("mode 0 preset wrong");
  m0_clock_a: assert property (is_m0 && $stable(mode) |=> o_txd == sclk_q) else $error("txd not shift clock");
  m0_ti_a: assert property (m0_ti |=> ctrl_q.tx_done_flag && m0_q == fsp_pkg::M0_IDLE)
    else $error("mode 0 tx flag missing");
  fe_sticky_a: assert property (fe_q && !(wr_ctrl && fsel) |=> fe_q) else $error("frame error self cleared");
  ri_sticky_a: assert property (ctrl_q.rx_done_flag && !wr_ctrl |=> ctrl_q.rx_done_flag)
    else $error("rx flag self cleared");
  rx_lost_a: assert property (rx_del && ctrl_q.rx_done_flag && !wr_ctrl |=> $stable(rxbuf_q))
    else $error("unread byte overwritten");
  ctrl7_read_a: assert property (ar_hs && ra == fsp_pkg::ADDR_CONTROL |=>
    o_rdata[7] == (fsel ? fe_q : ctrl_q.mode_select_high) || $changed(ctrl_q) || $changed(fe_q))
    else $error("control bit 7 mux wrong");
  tx_start_a: assert property (a_start |=> abusy_q && !o_txd) else $error("async start missing");
  fe_set_a: assert property (fe_set |=> fe_q) else $error("missing stop not flagged");
endmodule : fsp_serial_port

//--- bench/fsp_link_model.sv
// far-end model of the serial pins: frame catcher, frame sender, mode 0 shift receiver
`timescale 1ns/100ps
module fsp_link_model (
  // clock
  input  wire logic i_mclk,
  // pins seen from the far side
  input  wire logic i_txd,
  input  wire logic i_rxd_out,
  input  wire logic i_rxd_oe,
  input  wire logic i_m0,
  output logic      o_rxd
);
  localparam int BIT_CLKS = 32;
  logic [10:0] got;
  logic [7:0]  m0_got = 8'h00;
  int          m0_n   = 0;
  int          m0_span = 0;
  logic        txd_q  = 1'b1;
  logic        oe_q   = 1'b0;
  logic        dat_q  = 1'b1;
  initial o_rxd = 1'b1;
  // ----------------------------------------------------------------
  // async frames, sampled mid bit
  // ----------------------------------------------------------------
  task automatic catch_frame(input int nbits, input int bclks);
    got = 11'h000;
    @(negedge i_txd);
    repeat (bclks / 2) @(posedge i_mclk);
    for (int i = 0; i < nbits; i++) begin
      got[i] = i_txd;
      repeat (bclks) @(posedge i_mclk);
    end
  endtask : catch_frame
  // line idles high between frames, as a pulled-up receive line does
  task automatic send_frame(input logic [10:0] bits, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      @(posedge i_mclk);
      o_rxd <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge i_mclk);
    end
    @(posedge i_mclk);
    o_rxd <= 1'b1;
  endtask : send_frame
  // ----------------------------------------------------------------
  // mode 0: data held before each rising shift clock edge
  // ----------------------------------------------------------------
  // receive side: next bit set up right after each rising shift edge, top bit is idle
  task automatic send_m0(input logic [8:0] bits);
    time t0;
    t0 = 0;
    o_rxd <= bits[0];
    for (int i = 1; i < 9; i++) begin
      @(posedge i_txd);
      if (i == 1) t0 = $time;
      if (i == 7) m0_span = int'($time - t0);
      o_rxd <= bits[i];
    end
  endtask : send_m0
  always @(posedge i_mclk) begin
    txd_q <= i_txd;
    oe_q  <= i_rxd_oe;
    dat_q <= i_rxd_out;
    if (i_m0 && i_txd && !txd_q && oe_q) begin
      m0_got <= {dat_q, m0_got[7:1]};
      m0_n   <= m0_n + 1;
    end
  end
endmodule : fsp_link_model

//--- bench/fsp_serial_port_tb_top.sv
// self-checking bench of the four mode serial port
`timescale 1ns/100ps
module fsp_serial_port_tb_top;
  logic        mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, m0 = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd_d;
  logic        awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd, link_rxd;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  d;
  wire         rxd_pin;
  int          n_mismatch = 0, comparisons = 0;
  assign rxd_pin = rxd_oe ? rxd_out : link_rxd;
  fsp_serial_port dut_u (.i_mclk(mclk), .i_rstn(rstn), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_rxd(rxd_pin), .o_rxd_out(rxd_out), .o_rxd_oe(rxd_oe), .o_txd(txd));
  fsp_link_model link_u (.i_mclk(mclk), .i_txd(txd), .i_rxd_out(rxd_out), .i_rxd_oe(rxd_oe),
    .i_m0(m0), .o_rxd(link_rxd));
  initial forever #25 mclk = ~mclk;
  // ----------------------------------------------------------------
  // bus tasks and checking
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= {24'h0, a};
    wdata   <= {24'h0, v};
    fork
      begin do @(posedge mclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge mclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= {24'h0, a};
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rsp  = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_d, exp);
    check(32'(rsp), 32'(fsp_pkg::RESP_OKAY));
  endtask : rchk
  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 4; a <= 16; a += 4) rchk(8'(a), 32'h0);
    rd(8'h14);
    check(32'(rsp), 32'(fsp_pkg::RESP_SLVERR));
    wr(8'h14, 8'hff);
    check(32'(rsp), 32'(fsp_pkg::RESP_SLVERR));
    // 32 clocks a bit in every async mode: timer reload fe at full clock rate
    wr(fsp_pkg::ADDR_POWER, 8'h80);
    check(32'(rsp), 32'(fsp_pkg::RESP_OKAY));
    wr(fsp_pkg::ADDR_AUX, 8'h40);
    wr(fsp_pkg::ADDR_TIMER1, 8'hfe);
    for (int m = 1; m < 4; m++) begin
      wr(fsp_pkg::ADDR_CONTROL, {2'(m), 6'h08});
      d = 8'h5a ^ 8'(m * 17);
      fork
        link_u.catch_frame(m == 1 ? 10 : 11, 32);
        wr(fsp_pkg::ADDR_BUFFER, d);
      join
      check(32'(link_u.got), m == 1 ? {22'h0, 1'b1, d, 1'b0} : {21'h0, 2'b11, d, 1'b0});
      rchk(fsp_pkg::ADDR_CONTROL, {24'h0, 2'(m), 6'h0a});
    end
    wr(fsp_pkg::ADDR_CONTROL, 8'h98);
    link_u.send_frame({2'b11, 8'h3c, 1'b0}, 11);
    rchk(fsp_pkg::ADDR_BUFFER, 32'h3c);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h9d);
    link_u.send_frame({2'b10, 8'h55, 1'b0}, 11);
    rchk(fsp_pkg::ADDR_BUFFER, 32'h3c);
    wr(fsp_pkg::ADDR_CONTROL, 8'h50);
    link_u.send_frame({2'b01, 8'hc3, 1'b0}, 10);
    rchk(fsp_pkg::ADDR_BUFFER, 32'hc3);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h55);
    // mode written before the error view is selected, else bit 7 would set the error
    wr(fsp_pkg::ADDR_CONTROL, 8'h98);
    wr(fsp_pkg::ADDR_POWER, 8'hc0);
    link_u.send_frame({2'b00, 8'h0f, 1'b0}, 11);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h99);
    link_u.send_frame({2'b10, 8'h0f, 1'b0}, 11);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h99);
    wr(fsp_pkg::ADDR_CONTROL, 8'h18);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h18);
    wr(fsp_pkg::ADDR_POWER, 8'h80);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h98);
    // slow rates: mode 2 at clk/64, mode 3 with timer 1 prescaled and halved
    wr(fsp_pkg::ADDR_POWER, 8'h00);
    wr(fsp_pkg::ADDR_AUX, 8'h00);
    for (int m = 2; m < 4; m++) begin
      wr(fsp_pkg::ADDR_CONTROL, {2'(m), 6'h00});
      fork
        link_u.catch_frame(11, m == 2 ? 64 : 768);
        wr(fsp_pkg::ADDR_BUFFER, 8'h96);
      join
      check(32'(link_u.got), {21'h0, 2'b10, 8'h96, 1'b0});
    end
    wr(fsp_pkg::ADDR_CONTROL, 8'h00);
    wr(fsp_pkg::ADDR_AUX, 8'h20);
    m0 <= 1'b1;
    wr(fsp_pkg::ADDR_BUFFER, 8'h69);
    repeat (20) begin
      rd(fsp_pkg::ADDR_CONTROL);
      if (rd_d[1] === 1'b1) break;
    end
    check(rd_d, 32'h02);
    check(32'(link_u.m0_got), 32'h69);
    check(32'(link_u.m0_n), 32'h8);
    // mode 0 receive at clk/12, started by receiver_on with rx_done_flag clear
    wr(fsp_pkg::ADDR_AUX, 8'h00);
    fork
      link_u.send_m0({1'b1, 8'ha5});
      wr(fsp_pkg::ADDR_CONTROL, 8'h10);
    join
    repeat (2) @(posedge mclk);
    rchk(fsp_pkg::ADDR_BUFFER, 32'ha5);
    rchk(fsp_pkg::ADDR_CONTROL, 32'h11);
    check(32'(link_u.m0_span), 32'he10);
    finish_test();
  end
endmodule : fsp_serial_port_tb_top
